/* hdl/stl1_activation_fsm.sv */
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "stl1_cfg.svh"
// Overview of operation
// - Hardware reset pin acts exactly like the clear command.
// - Trunk mode: slip when wander exceeds 50 us, or 25 us if selected.
// - Slip state resynchronises buffer and is left after 0.5 ms.
// - Violation in a multiframe, if enabled, sends violation indication six times.
// - INFO 4 reports high or low priority activation from D-channel class.
// - Power-down keeps awake detector on; clocks stop only if stop bit set.
// - Clock request or static low upstream line powers up; clocks-on reported.
// - INFO 0 in F5..F8 gives pending deactivation; leave by line or deactivate.
// - Pending activation sends INFO 1 and clocks-on, waits indefinitely.
// - Line signal in power-down, power-up or pending states, or lost sync when synced or activated, goes unsynchronised, INFO 1 stops.
// - Synchronised on INFO 2 answers INFO 3, waits for INFO 4.
// - Activated about 0.5 ms after INFO 4 starts.
// - Loop command loops INFO 3 internally, INFO 0 on line, loop-closed shown.
// - Synced on loop shows loop active; line signal shows receiver unsynced.
// - Test modes send alternating pulses at 2 kHz or 96 kHz.
// - Reset state: analog off, INFO 0, awake detector off, no line activation.
// - Remote deactivation reported; clear and test commands acknowledged.
// - INFO 2 reports remote activation; unsynced signal reports unsynced.
// - Entering quiescent state reports deactivation confirm.
// - Receiver classes line as INFO 0, other signal, INFO 2, INFO 4.
module stl1_activation_fsm
	import stl1_pkg::*;
#(
	parameter int unsigned ACT_CYC    = `STL1_T_ACT_NS / `STL1_CLK_NS,
	parameter int unsigned SLIP_CYC   = `STL1_T_SLIP_NS / `STL1_CLK_NS,
	parameter int unsigned WANDER_CYC = `STL1_T_WANDER_NS / `STL1_CLK_NS,
	parameter int unsigned TM1_CYC    = `STL1_CLK_HZ / `STL1_TM1_HZ
)(
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [15:0]     reg_rdata,
	input  wire logic [3:0] ci_rx_code,
	input  wire logic       ci_frame_stb,
	output logic [3:0]      ci_tx_code,
	input  wire logic       hw_reset_pin,
	input  wire logic       upstream_data_line,
	input  wire logic [1:0] line_class,
	input  wire logic       rx_sync,
	input  wire logic       line_frame,
	input  wire logic       line_mframe,
	input  wire logic       line_cv,
	output logic [1:0]      line_tx_info,
	output logic            tx_pulse_pos,
	output logic            tx_pulse_neg,
	output logic            loop_en,
	output logic            analog_en,
	output logic            awake_det_en,
	output logic            bus_clk_en,
	output logic            buf_resync
);
	localparam logic [15:0] ACT_LAST  = 16'(ACT_CYC - 1);
	localparam logic [15:0] SLIP_LAST = 16'(SLIP_CYC - 1);
	localparam logic [15:0] WAND_W    = 16'(WANDER_CYC);
	localparam logic [15:0] WAND_N    = 16'(WANDER_CYC * `STL1_T_WNARROW_NS / `STL1_T_WANDER_NS);
	localparam logic [15:0] TM1_LAST  = 16'(TM1_CYC - 1);
	localparam logic [15:0] TM2_LAST  = 16'(`STL1_CLK_HZ / `STL1_TM2_HZ - 1);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 8;
	// Pins rest at idle level in reset, so no false edge or clock request follows
	localparam logic [NPIN-1:0] PIN_IDLE = `STL1_PIN_IDLE;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s;
	logic [NPIN-1:0] pin_prev_r;
	assign pin_raw = {hw_reset_pin, upstream_data_line, line_class, rx_sync,
		line_frame, line_mframe, line_cv};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_sync
			logic [2:0] sh_r;
			logic       val_r;
			always_ff @(posedge ref_clk)
			begin
				if (sys_rst)
				begin
					sh_r  <= {3{PIN_IDLE[gi]}};
					val_r <= PIN_IDLE[gi];
				end
				else
				begin
					sh_r <= {sh_r[1:0], pin_raw[gi]};
					if (sh_r[1] == sh_r[2])
						val_r <= sh_r[2];
				end
			end
			assign pin_s[gi] = val_r;
		end
	endgenerate

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			pin_prev_r <= PIN_IDLE;
		else
			pin_prev_r <= pin_s;
	end

	logic     rst_pin_s;
	logic     du_low;
	stl1_rx_t rx_cls;
	logic     rx_sync_s;
	logic     lf_edge;
	logic     mf_edge;
	logic     cv_edge;
	assign rst_pin_s = pin_s[7];
	assign du_low    = ~pin_s[6];
	assign rx_cls    = stl1_rx_t'(pin_s[5:4]);
	assign rx_sync_s = pin_s[3];
	assign lf_edge   = pin_s[2] & ~pin_prev_r[2];
	assign mf_edge   = pin_s[1] & ~pin_prev_r[1];
	assign cv_edge   = pin_s[0] & ~pin_prev_r[0];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic        ltt_r;
	logic        cfs_r;
	logic        far_code_violation_enable_r;
	logic        slipw_r;
	logic [3:0]  prio_r;
	stl1_state_t st_r;
	stl1_state_t st_nxt;
	logic [3:0]  cmd_r;
	logic [15:0] rdata_nxt;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ltt_r   <= 1'b0;
			cfs_r   <= 1'b0;
			far_code_violation_enable_r  <= 1'b0;
			slipw_r <= 1'b0;
			prio_r  <= `STL1_PRIO_RST;
		end
		else if (reg_wr && reg_addr == `STL1_ADDR_CTRL)
		begin
			ltt_r   <= reg_wdata[`STL1_CTRL_LTT];
			cfs_r   <= reg_wdata[`STL1_CTRL_CFS];
			far_code_violation_enable_r  <= reg_wdata[`STL1_CTRL_FAR_CODE_VIOLATION_ENABLE];
			slipw_r <= reg_wdata[`STL1_CTRL_SLIPW];
			prio_r  <= reg_wdata[`STL1_CTRL_PRIO_HI:`STL1_CTRL_PRIO_LO];
		end
	end

	always_comb
	begin
		rdata_nxt = 16'h0000;
		case (reg_addr)
			`STL1_ADDR_CTRL:   rdata_nxt = {8'h00, prio_r, slipw_r, far_code_violation_enable_r, cfs_r, ltt_r};
			`STL1_ADDR_STATUS: rdata_nxt = {3'h0, st_r};
			`STL1_ADDR_CI:     rdata_nxt = {8'h00, ci_tx_code, cmd_r};
			default:           rdata_nxt = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= 16'h0000;
	end

	// ----------------------------------------------------------------
	// Command acceptance
	// ----------------------------------------------------------------
	logic [3:0] cmd_last_r;
	logic       cmd_evt_r;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			cmd_last_r <= 4'hF;
			cmd_r      <= 4'hF;
			cmd_evt_r  <= 1'b0;
		end
		else
		begin
			cmd_evt_r <= 1'b0;
			if (ci_frame_stb)
			begin
				cmd_last_r <= ci_rx_code;
				if (ci_rx_code == cmd_last_r && ci_rx_code != cmd_r)
				begin
					cmd_r     <= ci_rx_code;
					cmd_evt_r <= 1'b1;
				end
			end
		end
	end

	logic c_clear;
	logic c_deact;
	logic c_ar;
	logic c_clkreq;
	assign c_clear  = cmd_evt_r && cmd_r == STL1_C_CLEAR;
	assign c_deact  = cmd_evt_r && cmd_r == STL1_C_DEACT;
	assign c_ar     = cmd_evt_r && (cmd_r == STL1_C_AR8 || cmd_r == STL1_C_ACTIVATE_PRIO_LOW_CMD);
	assign c_clkreq = cmd_r == STL1_C_CLKREQ || du_low;

	// ----------------------------------------------------------------
	// Wander measurement and slip detection
	// ----------------------------------------------------------------
	logic [15:0] offs_r;
	logic [15:0] wmin_r;
	logic [15:0] wmax_r;
	logic        wval_r;
	logic        slip_det;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			offs_r <= 16'h0000;
		else if (ci_frame_stb)
			offs_r <= 16'h0000;
		else if (offs_r != 16'hFFFF)
			offs_r <= offs_r + 16'h0001;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || st_r != STL1_ACTIV)
		begin
			wval_r <= 1'b0;
			wmin_r <= 16'h0000;
			wmax_r <= 16'h0000;
		end
		else if (lf_edge)
		begin
			wval_r <= 1'b1;
			if (!wval_r || offs_r < wmin_r)
				wmin_r <= offs_r;
			if (!wval_r || offs_r > wmax_r)
				wmax_r <= offs_r;
		end
	end
	assign slip_det = ltt_r && wval_r && (wmax_r - wmin_r) > (slipw_r ? WAND_N : WAND_W);

	// ----------------------------------------------------------------
	// State machine
	// ----------------------------------------------------------------
	logic [15:0] tmr_r;
	logic        tmr_done;
	assign tmr_done = st_r == STL1_SLIP ? tmr_r == SLIP_LAST : tmr_r == ACT_LAST;

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			STL1_RESET:
				if (c_deact) st_nxt = STL1_PDOWN;
				else if (c_ar) st_nxt = STL1_PACT;
				else if (cmd_evt_r && c_clkreq) st_nxt = STL1_PUP;
			STL1_PDOWN:
				if (rx_cls != STL1_RX_INFO0) st_nxt = STL1_UNSYNC;
				else if (c_ar) st_nxt = STL1_PACT;
				else if (c_clkreq) st_nxt = STL1_PUP;
			STL1_PUP, STL1_PDEACT, STL1_PACT:
				if (c_deact) st_nxt = STL1_PDOWN;
				else if (rx_cls != STL1_RX_INFO0) st_nxt = STL1_UNSYNC;
				else if (c_ar && st_r == STL1_PUP) st_nxt = STL1_PACT;
			STL1_UNSYNC:
				if (c_deact) st_nxt = STL1_PDOWN;
				else if (rx_cls == STL1_RX_INFO0) st_nxt = STL1_PDEACT;
				else if (rx_sync_s && rx_cls[1]) st_nxt = STL1_SYNC;
			STL1_SYNC:
				if (rx_cls == STL1_RX_INFO0) st_nxt = STL1_PDEACT;
				else if (!rx_sync_s) st_nxt = STL1_UNSYNC;
				else if (rx_cls == STL1_RX_INFO4 && tmr_done) st_nxt = STL1_ACTIV;
			STL1_ACTIV:
				if (rx_cls == STL1_RX_INFO0) st_nxt = STL1_PDEACT;
				else if (!rx_sync_s) st_nxt = STL1_UNSYNC;
				else if (slip_det) st_nxt = STL1_SLIP;
			STL1_SLIP:
				if (rx_cls == STL1_RX_INFO0) st_nxt = STL1_PDEACT;
				else if (tmr_done) st_nxt = STL1_ACTIV;
			STL1_LOOPC:
				if (c_deact) st_nxt = STL1_PDOWN;
				else if (rx_sync_s) st_nxt = STL1_LOOPA;
			STL1_LOOPA, STL1_TEST1, STL1_TEST2:
				if (c_deact) st_nxt = STL1_PDOWN;
			default:
				st_nxt = STL1_RESET;
		endcase
		if (cmd_evt_r && cmd_r == STL1_C_LOOP) st_nxt = STL1_LOOPC;
		if (cmd_evt_r && cmd_r == STL1_C_TEST1) st_nxt = STL1_TEST1;
		if (cmd_evt_r && cmd_r == STL1_C_TEST2) st_nxt = STL1_TEST2;
		if (c_clear || rst_pin_s) st_nxt = STL1_RESET;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			st_r <= STL1_RESET;
		else
			st_r <= st_nxt;
	end

	// Phase timer for the 0.5 ms holds
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || st_nxt != st_r)
			tmr_r <= 16'h0000;
		else if ((st_r == STL1_SYNC && rx_cls == STL1_RX_INFO4) || st_r == STL1_SLIP)
		begin
			if (!tmr_done)
				tmr_r <= tmr_r + 16'h0001;
		end
		else
			tmr_r <= 16'h0000;
	end

	// ----------------------------------------------------------------
	// Violation indication repeat
	// ----------------------------------------------------------------
	logic       cv_seen_r;
	logic [3:0] cvr_cnt_r;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			cv_seen_r <= 1'b0;
			cvr_cnt_r <= 4'h0;
		end
		else
		begin
			cv_seen_r <= cv_edge | (cv_seen_r & ~mf_edge);
			if (mf_edge && far_code_violation_enable_r && (cv_seen_r || cv_edge))
				cvr_cnt_r <= `STL1_CVR_REPEAT;
			else if (ci_frame_stb && cvr_cnt_r != 4'h0)
				cvr_cnt_r <= cvr_cnt_r - 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Indications
	// ----------------------------------------------------------------
	stl1_ind_t ind_nxt;
	always_comb
	begin
		ind_nxt = STL1_I_IDLE;
		case (st_r)
			STL1_RESET:  ind_nxt = STL1_I_RES;
			STL1_PDOWN:  ind_nxt = STL1_I_DC;
			STL1_PUP:    ind_nxt = bus_clk_en ? STL1_I_PU : STL1_I_DC;
			STL1_PDEACT: ind_nxt = STL1_I_DR;
			STL1_PACT:   ind_nxt = STL1_I_PU;
			STL1_UNSYNC:
				if (rx_cls == STL1_RX_INFO2) ind_nxt = STL1_I_AR;
				else ind_nxt = STL1_I_RSY;
			STL1_SYNC:   ind_nxt = STL1_I_AR;
			STL1_ACTIV:  ind_nxt = prio_r < `STL1_PRIO_LOW ? STL1_I_AI8 : STL1_I_ACTIVE_PRIO_LOW_IND;
			STL1_SLIP:   ind_nxt = STL1_I_SLIP;
			STL1_LOOPC:  ind_nxt = STL1_I_ARL;
			STL1_LOOPA:  ind_nxt = rx_cls != STL1_RX_INFO0 ? STL1_I_RSY : STL1_I_AIL;
			STL1_TEST1:  ind_nxt = STL1_I_TM1;
			STL1_TEST2:  ind_nxt = STL1_I_TM2;
			default:     ind_nxt = STL1_I_IDLE;
		endcase
		if (cvr_cnt_r != 4'h0) ind_nxt = STL1_I_CVR;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			ci_tx_code <= STL1_I_RES;
		else
			ci_tx_code <= ind_nxt;
	end

	// ----------------------------------------------------------------
	// Line side controls
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			line_tx_info <= STL1_TX_INFO0;
			loop_en      <= 1'b0;
			analog_en    <= 1'b0;
			awake_det_en <= 1'b0;
			bus_clk_en   <= 1'b1;
			buf_resync   <= 1'b0;
		end
		else
		begin
			case (st_r)
				STL1_PACT: line_tx_info <= STL1_TX_INFO1;
				STL1_SYNC, STL1_ACTIV, STL1_SLIP: line_tx_info <= STL1_TX_INFO3;
				STL1_TEST1, STL1_TEST2: line_tx_info <= STL1_TX_PULSE;
				default: line_tx_info <= STL1_TX_INFO0;
			endcase
			loop_en      <= st_r == STL1_LOOPC || st_r == STL1_LOOPA;
			analog_en    <= st_r != STL1_RESET;
			awake_det_en <= st_r != STL1_RESET;
			bus_clk_en   <= !(st_r == STL1_PDOWN && !ltt_r && cfs_r);
			buf_resync   <= st_r == STL1_SLIP;
		end
	end

	// Test pulse generator
	logic [15:0] ptmr_r;
	logic        pol_r;
	logic        ptick;
	assign ptick = st_r == STL1_TEST1 ? ptmr_r == TM1_LAST : ptmr_r == TM2_LAST;
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst || (st_r != STL1_TEST1 && st_r != STL1_TEST2))
		begin
			ptmr_r       <= 16'h0000;
			pol_r        <= 1'b0;
			tx_pulse_pos <= 1'b0;
			tx_pulse_neg <= 1'b0;
		end
		else
		begin
			ptmr_r <= ptick ? 16'h0000 : ptmr_r + 16'h0001;
			if (ptick)
				pol_r <= ~pol_r;
			tx_pulse_pos <= (ptick || st_r == STL1_TEST2) && !pol_r;
			tx_pulse_neg <= (ptick || st_r == STL1_TEST2) && pol_r;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	AST_RST_PIN: assert property (rst_pin_s |=> st_r == STL1_RESET)
		else $error("reset pin did not clear state");
	AST_RESET_OUT: assert property (st_r == STL1_RESET |=>
		!analog_en && !awake_det_en && line_tx_info == STL1_TX_INFO0)
		else $error("reset state outputs wrong");
	AST_SLIP_LTT: assert property (st_r == STL1_SLIP |-> ltt_r)
		else $error("slip outside trunk mode");
	AST_SLIP_HOLD: assert property ($rose(st_r == STL1_SLIP) |-> tmr_r == 16'h0000 ##1
		(st_r == STL1_SLIP) [*8])
		else $error("slip state left too early");
	AST_ACT_DELAY: assert property ($past(st_r) == STL1_SYNC && st_r == STL1_ACTIV
		|-> $past(tmr_r) == ACT_LAST)
		else $error("activation delay wrong");
	AST_CVR: assert property (cvr_cnt_r != 4'h0 |=> ci_tx_code == STL1_I_CVR)
		else $error("violation indication missing");
	AST_PRIO: assert property (st_r == STL1_ACTIV && cvr_cnt_r == 4'h0 && prio_r < 4'hA
		|=> ci_tx_code == STL1_I_AI8)
		else $error("priority indication wrong");
	AST_CLK_STOP: assert property (st_r == STL1_PDOWN && !ltt_r && cfs_r ##1
		st_r == STL1_PDOWN |-> !bus_clk_en && awake_det_en)
		else $error("clock stop wrong");
	AST_PACT: assert property (st_r == STL1_PACT && cvr_cnt_r == 4'h0 |=>
		line_tx_info == STL1_TX_INFO1 && ci_tx_code == STL1_I_PU)
		else $error("pending activation outputs wrong");
	AST_LOOP: assert property (st_r == STL1_LOOPC |=> loop_en
		&& line_tx_info == STL1_TX_INFO0)
		else $error("loop outputs wrong");

	COV_ACTIVE: cover property (st_r == STL1_SYNC ##1 st_r == STL1_ACTIV);
	COV_SLIP: cover property (st_r == STL1_SLIP ##1 st_r == STL1_ACTIV);
	COV_LOOP: cover property (st_r == STL1_LOOPC ##1 st_r == STL1_LOOPA);
	COV_DEACT: cover property (st_r == STL1_PDEACT ##1 st_r == STL1_PDOWN);

endmodule : stl1_activation_fsm
`default_nettype wire

/* hdl/stl1_cfg.svh */
`ifndef STL1_CFG_SVH
`define STL1_CFG_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STL1_CLK_HZ        100000000
`define STL1_CLK_NS        10
`define STL1_T_ACT_NS      500000
`define STL1_T_SLIP_NS     500000
`define STL1_T_WANDER_NS   50000
`define STL1_T_WNARROW_NS  25000
`define STL1_TM1_HZ        2000
`define STL1_TM2_HZ        96000
`define STL1_CVR_REPEAT    4'h6
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define STL1_ADDR_CTRL     8'h00
`define STL1_ADDR_STATUS   8'h04
`define STL1_ADDR_CI       8'h08
`define STL1_CTRL_LTT      0
`define STL1_CTRL_CFS      1
`define STL1_CTRL_FAR_CODE_VIOLATION_ENABLE     2
`define STL1_CTRL_SLIPW    3
`define STL1_CTRL_PRIO_LO  4
`define STL1_CTRL_PRIO_HI  7
`define STL1_PRIO_RST      4'h8
`define STL1_PRIO_LOW      4'hA
`define STL1_PIN_IDLE      8'h40
`endif

/* hdl/stl1_pkg.sv */
package stl1_pkg;
	// States, one-hot
	typedef enum logic [12:0] {
		STL1_RESET  = 13'h0001,
		STL1_PDOWN  = 13'h0002,
		STL1_PUP    = 13'h0004,
		STL1_PDEACT = 13'h0008,
		STL1_PACT   = 13'h0010,
		STL1_UNSYNC = 13'h0020,
		STL1_SYNC   = 13'h0040,
		STL1_ACTIV  = 13'h0080,
		STL1_SLIP   = 13'h0100,
		STL1_LOOPC  = 13'h0200,
		STL1_LOOPA  = 13'h0400,
		STL1_TEST1  = 13'h0800,
		STL1_TEST2  = 13'h1000
	} stl1_state_t;
	// Command codes; all but clock request and deactivate are arbitrary
	typedef enum logic [3:0] {
		STL1_C_CLKREQ = 4'h0,
		STL1_C_CLEAR  = 4'h1,
		STL1_C_TEST1  = 4'h2,
		STL1_C_TEST2  = 4'h3,
		STL1_C_LOOP   = 4'h4,
		STL1_C_AR8    = 4'h8,
		STL1_C_ACTIVATE_PRIO_LOW_CMD   = 4'h9,
		STL1_C_DEACT  = 4'hF
	} stl1_cmd_t;
	// Indication codes; values arbitrary
	typedef enum logic [3:0] {
		STL1_I_DC    = 4'h0,
		STL1_I_RES   = 4'h1,
		STL1_I_TM1   = 4'h2,
		STL1_I_TM2   = 4'h3,
		STL1_I_SLIP  = 4'h4,
		STL1_I_RSY   = 4'h5,
		STL1_I_PU    = 4'h6,
		STL1_I_AR    = 4'h7,
		STL1_I_ARL   = 4'h8,
		STL1_I_CVR   = 4'h9,
		STL1_I_AIL   = 4'hA,
		STL1_I_AI8   = 4'hB,
		STL1_I_ACTIVE_PRIO_LOW_IND  = 4'hC,
		STL1_I_DR    = 4'hD,
		STL1_I_IDLE  = 4'hF
	} stl1_ind_t;
	typedef enum logic [1:0] {
		STL1_TX_INFO0 = 2'h0,
		STL1_TX_INFO1 = 2'h1,
		STL1_TX_INFO3 = 2'h2,
		STL1_TX_PULSE = 2'h3
	} stl1_tx_t;
	typedef enum logic [1:0] {
		STL1_RX_INFO0 = 2'h0,
		STL1_RX_SIG   = 2'h1,
		STL1_RX_INFO2 = 2'h2,
		STL1_RX_INFO4 = 2'h3
	} stl1_rx_t;
endpackage : stl1_pkg

/* sim/stl1_nt_model.sv */
`timescale 1ns/1ps
`default_nettype none
module stl1_nt_model
	import stl1_pkg::*;
#(
	parameter int FRAME_CYC = 25,
	parameter int SYNC_DLY  = 6
)(
	input  wire logic       ref_clk,
	input  wire logic [1:0] want,
	input  wire logic       sync_on,
	input  wire logic       loop_in,
	input  wire logic       cv_on,
	output logic [1:0]      line_class,
	output logic            rx_sync,
	output logic            line_frame,
	output logic            line_mframe,
	output logic            line_cv
);
	int fcnt_r = 0;
	int frm_r  = 0;
	int scnt_r = 0;
	logic sig;
	assign sig = (want != STL1_RX_INFO0);
	// ----------------------------------------------------------------
	// Line signal and framing
	// ----------------------------------------------------------------
	// Framing stands still while only INFO 0 is on the line
	always_ff @(posedge ref_clk)
	begin
		line_class <= want;
		fcnt_r <= (!sig || fcnt_r == FRAME_CYC - 1) ? 0 : fcnt_r + 1;
		line_frame <= sig && (fcnt_r < FRAME_CYC / 2);
		if (sig && fcnt_r == 0)
			frm_r <= frm_r + 1;
		line_mframe <= sig && (frm_r % 4 == 0) && (fcnt_r < FRAME_CYC / 2);
		// Violation three cycles wide so it survives the receiver's filter
		line_cv <= cv_on && sig && fcnt_r >= 3 && fcnt_r < 6;
	end
	// ----------------------------------------------------------------
	// Receiver lock, slow to gain and instant to lose
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		scnt_r <= (sync_on && (sig || loop_in)) ? scnt_r + 1 : 0;
		rx_sync <= (scnt_r >= SYNC_DLY);
	end
endmodule : stl1_nt_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stl1_cfg.svh"
module tb;
	import stl1_pkg::*;
	localparam int ACT = 20;
	logic        ref_clk, sys_rst, reg_wr, reg_rd, ci_frame_stb, hw_reset_pin;
	logic        sync_on, upstream_data_line, rx_sync, line_frame, line_mframe, line_cv;
	logic        tx_pulse_pos, tx_pulse_neg, loop_en, analog_en, awake_det_en, bus_clk_en;
	logic        buf_resync, cv_on, stb_d;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [3:0]  ci_rx_code, ci_tx_code;
	logic [1:0]  want, line_class, line_tx_info;
	int          n_errors = 0;
	int          tests_run = 0;
	int          seed = 32'h52DADE64;
	int          cyc = 0;
	int          fcnt = 0;
	int          npul;
	logic        rd_p = 1'b0;
	typedef struct { logic [15:0] e; logic [15:0] m; } stl1_note_t;
	stl1_note_t  q[$];

	stl1_activation_fsm #(.ACT_CYC(ACT), .SLIP_CYC(20), .WANDER_CYC(4), .TM1_CYC(40)) u_dut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ci_rx_code(ci_rx_code),
		.ci_frame_stb(ci_frame_stb), .ci_tx_code(ci_tx_code), .hw_reset_pin(hw_reset_pin),
		.upstream_data_line(upstream_data_line), .line_class(line_class), .rx_sync(rx_sync),
		.line_frame(line_frame), .line_mframe(line_mframe), .line_cv(line_cv),
		.line_tx_info(line_tx_info), .tx_pulse_pos(tx_pulse_pos), .tx_pulse_neg(tx_pulse_neg),
		.loop_en(loop_en), .analog_en(analog_en), .awake_det_en(awake_det_en),
		.bus_clk_en(bus_clk_en), .buf_resync(buf_resync));

	stl1_nt_model u_nt (
		.ref_clk(ref_clk), .want(want), .sync_on(sync_on), .loop_in(loop_en), .cv_on(cv_on),
		.line_class(line_class), .rx_sync(rx_sync), .line_frame(line_frame),
		.line_mframe(line_mframe), .line_cv(line_cv));

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// Frame strobe, timeout and read-data watcher
	// ----------------------------------------------------------------
	always @(posedge ref_clk)
	begin
		fcnt <= (fcnt == 7) ? 0 : fcnt + 1;
		ci_frame_stb <= (fcnt == 7);
		cyc <= cyc + 1;
		if (rd_p && q.size() > 0)
		begin
			chk("reg_rdata", q[0].e & q[0].m, reg_rdata & q[0].m);
			void'(q.pop_front());
		end
		rd_p <= reg_rd;
		if (cyc == 20000)
		begin
			n_errors++;
			close_out();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		q.push_back('{e, m});
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : rd

	task automatic st(input stl1_state_t s, input stl1_ind_t i, input logic [1:0] tx);
		rd(`STL1_ADDR_STATUS, {3'h0, s}, 16'hFFFF);
		rd(`STL1_ADDR_CI, {8'h00, i, 4'h0}, 16'h00F0);
		chk("line_tx_info", 16'(tx), 16'(line_tx_info));
	endtask : st

	// One random single-frame code first; it must not be taken
	task automatic cmd(input logic [3:0] c);
		ci_rx_code <= 4'($random(seed));
		repeat (8) @(posedge ref_clk);
		ci_rx_code <= c;
		repeat (40) @(posedge ref_clk);
	endtask : cmd

	task automatic line(input logic [1:0] w, input logic s);
		want <= w;
		sync_on <= s;
		repeat (24) @(posedge ref_clk);
	endtask : line

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : close_out
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		ci_rx_code = 4'h1;
		hw_reset_pin = 1'b0;
		upstream_data_line = 1'b1;
		want = STL1_RX_INFO0;
		sync_on = 1'b0;
		ci_frame_stb = 1'b0;
		cv_on = 1'b0;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		st(STL1_RESET, STL1_I_RES, STL1_TX_INFO0);
		chk("analog_en", 16'h0000, 16'(analog_en));
		chk("awake_det_en", 16'h0000, 16'(awake_det_en));
		rd(`STL1_ADDR_CTRL, {8'h00, `STL1_PRIO_RST, 4'h0}, 16'hFFFF);
		rd(8'h0C, 16'h0000, 16'hFFFF);
		wr(`STL1_ADDR_STATUS, 16'hFFFF);
		line(STL1_RX_SIG, 1'b0);
		st(STL1_RESET, STL1_I_RES, STL1_TX_INFO0);
		line(STL1_RX_INFO0, 1'b0);
		$display("test reset done");
		for (int p = 8; p < 12; p++)
		begin
			wr(`STL1_ADDR_CTRL, {8'h00, p[3:0], 4'h0});
			cmd(($random(seed) & 1) ? STL1_C_AR8 : STL1_C_ACTIVATE_PRIO_LOW_CMD);
			st(STL1_PACT, STL1_I_PU, STL1_TX_INFO1);
			line(STL1_RX_SIG, 1'b0);
			st(STL1_UNSYNC, STL1_I_RSY, STL1_TX_INFO0);
			line(STL1_RX_INFO2, 1'b1);
			st(STL1_SYNC, STL1_I_AR, STL1_TX_INFO3);
			want <= STL1_RX_INFO4;
			repeat (6) @(posedge ref_clk);
			st(STL1_SYNC, STL1_I_AR, STL1_TX_INFO3);
			repeat (ACT + 10) @(posedge ref_clk);
			st(STL1_ACTIV, (p < 10) ? STL1_I_AI8 : STL1_I_ACTIVE_PRIO_LOW_IND, STL1_TX_INFO3);
			line(STL1_RX_INFO0, 1'b0);
			st(STL1_PDEACT, STL1_I_DR, STL1_TX_INFO0);
			cmd(STL1_C_CLEAR);
			st(STL1_RESET, STL1_I_RES, STL1_TX_INFO0);
		end
		$display("test activation done");
		wr(`STL1_ADDR_CTRL, 16'h0082);
		cmd(STL1_C_DEACT);
		st(STL1_PDOWN, STL1_I_DC, STL1_TX_INFO0);
		chk("awake_det_en", 16'h0001, 16'(awake_det_en));
		chk("bus_clk_en", 16'h0000, 16'(bus_clk_en));
		cmd(STL1_C_CLKREQ);
		st(STL1_PUP, STL1_I_PU, STL1_TX_INFO0);
		chk("bus_clk_en", 16'h0001, 16'(bus_clk_en));
		cmd(STL1_C_DEACT);
		upstream_data_line <= 1'b0;
		repeat (24) @(posedge ref_clk);
		st(STL1_PUP, STL1_I_PU, STL1_TX_INFO0);
		upstream_data_line <= 1'b1;
		$display("test power done");
		cmd(STL1_C_TEST1);
		st(STL1_TEST1, STL1_I_TM1, STL1_TX_PULSE);
		npul = 0;
		repeat (200)
		begin
			@(posedge ref_clk);
			npul += tx_pulse_pos + tx_pulse_neg;
		end
		chk("pulse count", 16'h0005, 16'(npul));
		cmd(STL1_C_TEST2);
		st(STL1_TEST2, STL1_I_TM2, STL1_TX_PULSE);
		chk("tx_pulse", 16'h0001, 16'(tx_pulse_pos ^ tx_pulse_neg));
		$display("test pulse done");
		cmd(STL1_C_LOOP);
		st(STL1_LOOPC, STL1_I_ARL, STL1_TX_INFO0);
		chk("loop_en", 16'h0001, 16'(loop_en));
		line(STL1_RX_INFO0, 1'b1);
		st(STL1_LOOPA, STL1_I_AIL, STL1_TX_INFO0);
		line(STL1_RX_SIG, 1'b1);
		rd(`STL1_ADDR_CI, {8'h00, STL1_I_RSY, 4'h0}, 16'h00F0);
		hw_reset_pin <= 1'b1;
		repeat (12) @(posedge ref_clk);
		st(STL1_RESET, STL1_I_RES, STL1_TX_INFO0);
		chk("loop_en", 16'h0000, 16'(loop_en));
		hw_reset_pin <= 1'b0;
		$display("test loop done");
		wr(`STL1_ADDR_CTRL, 16'h0084);
		cmd(STL1_C_AR8);
		line(STL1_RX_INFO2, 1'b1);
		want <= STL1_RX_INFO4;
		repeat (ACT + 10) @(posedge ref_clk);
		@(posedge line_frame);
		cv_on <= 1'b1;
		repeat (10) @(posedge ref_clk);
		cv_on <= 1'b0;
		npul = 0;
		stb_d = 1'b0;
		repeat (250)
		begin
			@(posedge ref_clk);
			if (stb_d && ci_tx_code == STL1_I_CVR)
				npul++;
			stb_d = ci_frame_stb;
		end
		chk("cvr frames", 16'h0006, 16'(npul));
		wr(`STL1_ADDR_CTRL, 16'h0081);
		npul = 0;
		repeat (400)
		begin
			@(posedge ref_clk);
			if (buf_resync)
			begin
				npul++;
				if (npul == 1)
					chk("ci_tx_code", 16'(STL1_I_SLIP), 16'(ci_tx_code));
			end
			else if (npul > 0)
				break;
		end
		chk("slip cycles", 16'h0014, 16'(npul));
		line(STL1_RX_INFO0, 1'b0);
		st(STL1_PDEACT, STL1_I_DR, STL1_TX_INFO0);
		$display("test line done");
		repeat (10) @(posedge ref_clk);
		close_out();
	end
endmodule : tb
`default_nettype wire
